// ==== logic/pmon_datapath.sv ====
/*
 * measurement-result datapath: timed conversions, averaging, current and
 * power derivation, and the register file read through the address port.
 * assumes the analog front end presents settled codes on its sample inputs
 * and that the serial bus engine drives the register port one access a cycle.
 */
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// RL1: identity register at 3eh, fixed, write-ignored
// RL2: range bit clear wide, set narrow
// RL3: wide range: 2.5 uV per count
// RL4: narrow range: 625 nV per count
// RL5: bus result 1.6 mV per count
// RL6: shunt at 1h, bus at 2h
// RL7: shunt result is signed
// RL8: bus result is unsigned
// RL9: current recomputed each measurement; zero cal zeroes
// RL10: current is shunt times cal over 2048
// RL11: host picks current step above max/32768
// RL12: power watts equal 32 times step times code
// RL13: current from shunt, power from current and bus
// RL14: selectable conversion time and averaging, 140 us minimum
// RL15: all results commit together after arithmetic
module pmon_datapath #(
    parameter int unsigned         CYC_PER_US = pmon_pkg::CLK_MHZ,
    parameter logic        [15:0]  MAKER_ID   = 16'h5a5a  // arbitrary value
) (
    input  wire logic                  clk_i,
    input  wire logic                  arst_n_i,
    input  wire pmon_pkg::pmon_reg_req_t reg_req_i,
    input  wire logic                  reg_rd_i,
    output logic               [15:0]  reg_rdata_o,
    input  wire logic          [15:0]  shunt_cal_i,
    input  wire logic signed   [15:0]  shunt_sample_i,
    input  wire logic          [15:0]  bus_sample_i,
    output logic                       shunt_range_select_o,
    output logic                       sample_strobe_o,
    output logic                       result_ready_o,
    output logic                       math_ovf_o,
    output pmon_pkg::pmon_result_t     result_o
);

    // ****************************************************************
    // configuration register
    // ****************************************************************
    logic [15:0] config_q;
    logic        cfg_wr;

    assign cfg_wr = reg_req_i.wr && (reg_req_i.addr == pmon_pkg::ADDR_CONFIG);

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            config_q <= pmon_pkg::CFG_RESET;
        end else if (cfg_wr) begin
            config_q <= reg_req_i.wdata & pmon_pkg::CFG_WR_MASK;
        end
    end

    // front end scales by 2.5 uV (clear) or 625 nV (set) per count
    assign shunt_range_select_o = config_q[pmon_pkg::CFG_RANGE_BIT]; // RL2 RL3 RL4

    logic [pmon_pkg::CONV_SEL_W-1:0] conv_sel;
    logic [pmon_pkg::CFG_AVG_W-1:0]  avg_sel;
    logic [2:0]                      avg_log2;

    assign conv_sel = config_q[pmon_pkg::CFG_CONV_LSB +: pmon_pkg::CONV_SEL_W];
    assign avg_sel  = config_q[pmon_pkg::CFG_AVG_LSB +: pmon_pkg::CFG_AVG_W];
    assign avg_log2 = pmon_pkg::pmon_avg_log2(avg_sel);

    // ****************************************************************
    // conversion timer
    // ****************************************************************
    pmon_pkg::pmon_state_t                 state_q;
    logic [pmon_pkg::CONV_CNT_W-1:0]       conv_cnt_q;
    logic [pmon_pkg::CONV_CNT_W-1:0]       conv_len;
    logic                                  conv_end;

    assign conv_len = pmon_pkg::CONV_CNT_W'(pmon_pkg::pmon_conv_us(conv_sel) * CYC_PER_US); // RL14
    assign conv_end = (state_q == pmon_pkg::PMON_CONVERT) && (conv_cnt_q >= conv_len - 1'b1);
    assign sample_strobe_o = conv_end;

    // a configuration write restarts the conversion so no sample mixes settings
    // the timer keeps running through the arithmetic so the period stays exact
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            conv_cnt_q <= '0;
        end else if (cfg_wr || conv_end) begin
            conv_cnt_q <= '0;
        end else begin
            conv_cnt_q <= conv_cnt_q + 1'b1;
        end
    end

    // ****************************************************************
    // averaging
    // ****************************************************************
    logic signed [21:0] shunt_acc_q;
    logic        [21:0] bus_acc_q;
    logic        [5:0]  avg_cnt_q;
    logic               avg_last;
    logic signed [21:0] shunt_sum;
    logic        [21:0] bus_sum;
    logic signed [15:0] shunt_avg_q;
    logic        [15:0] bus_avg_q;

    assign avg_last  = (avg_cnt_q == 6'((7'h01 << avg_log2) - 7'h01));
    assign shunt_sum = shunt_acc_q + 22'(shunt_sample_i); // RL7
    assign bus_sum   = bus_acc_q + {6'h00, bus_sample_i}; // RL8

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            shunt_acc_q <= '0;
            bus_acc_q   <= '0;
            avg_cnt_q   <= '0;
            shunt_avg_q <= 16'sh0000;
            bus_avg_q   <= 16'h0000;
        end else if (cfg_wr) begin
            shunt_acc_q <= '0;
            bus_acc_q   <= '0;
            avg_cnt_q   <= '0;
        end else if (conv_end) begin
            if (avg_last) begin
                shunt_acc_q <= '0;
                bus_acc_q   <= '0;
                avg_cnt_q   <= '0;
                shunt_avg_q <= 16'(shunt_sum >>> avg_log2); // RL14 RL7
                bus_avg_q   <= 16'(bus_sum >> avg_log2); // RL8 RL5
            end else begin
                shunt_acc_q <= shunt_sum;
                bus_acc_q   <= bus_sum;
                avg_cnt_q   <= avg_cnt_q + 1'b1;
            end
        end
    end

    // ****************************************************************
    // sequencing
    // ****************************************************************
    logic math_start;
    logic math_done;
    logic math_ovf;
    logic signed [15:0] math_current;
    logic        [15:0] math_power;

    assign math_start = conv_end && avg_last && !cfg_wr;

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state_q <= pmon_pkg::PMON_CONVERT;
        end else begin
            case (state_q)
                pmon_pkg::PMON_CONVERT: begin
                    if (conv_end && avg_last && !cfg_wr) begin
                        state_q <= pmon_pkg::PMON_MATH;
                    end
                end
                pmon_pkg::PMON_MATH: begin
                    if (math_done) begin
                        state_q <= pmon_pkg::PMON_COMMIT;
                    end
                end
                pmon_pkg::PMON_COMMIT: begin
                    state_q <= pmon_pkg::PMON_CONVERT;
                end
                default: begin
                    state_q <= pmon_pkg::PMON_CONVERT;
                end
            endcase
        end
    end

    // averaged codes are captured a cycle after start, so math waits one cycle
    logic math_go_q;

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            math_go_q <= 1'b0;
        end else begin
            math_go_q <= math_start;
        end
    end

    pmon_math u_math (
        .clk_i     (clk_i),
        .arst_n_i  (arst_n_i),
        .start_i   (math_go_q),
        .shunt_i   (shunt_avg_q),
        .bus_i     (bus_avg_q),
        .cal_i     (shunt_cal_i),
        .done_o    (math_done),
        .ovf_o     (math_ovf),
        .current_o (math_current),
        .power_o   (math_power)
    );

    // ****************************************************************
    // result commit
    // ****************************************************************
    // one commit edge for all four keeps any read self-consistent
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            result_o       <= '{default: '0};
            math_ovf_o     <= 1'b0;
            result_ready_o <= 1'b0;
        end else begin
            result_ready_o <= 1'b0;
            if (math_done) begin
                result_o.shunt   <= shunt_avg_q; // RL15
                result_o.bus     <= bus_avg_q; // RL15
                result_o.current <= math_current; // RL15 RL9
                result_o.power   <= math_power; // RL15 RL12
                math_ovf_o       <= math_ovf;
                result_ready_o   <= 1'b1;
            end
        end
    end

    // ****************************************************************
    // register read port
    // ****************************************************************
    // writes to result and identity offsets simply fall through unused
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            reg_rdata_o <= pmon_pkg::RESULT_RESET;
        end else if (reg_rd_i) begin
            case (reg_req_i.addr)
                pmon_pkg::ADDR_CONFIG:   reg_rdata_o <= config_q;
                pmon_pkg::ADDR_SHUNT:    reg_rdata_o <= result_o.shunt; // RL6
                pmon_pkg::ADDR_BUS:      reg_rdata_o <= result_o.bus; // RL6
                pmon_pkg::ADDR_MAKER_ID: reg_rdata_o <= MAKER_ID; // RL1
                default:                 reg_rdata_o <= 16'h0000;
            endcase
        end
    end

endmodule

`default_nettype wire

// ==== logic/pmon_pkg.sv ====
/*
 * shared constants and types of the shunt power monitor datapath.
 * assumes a 50 mhz core clock and 16-bit register words.
 */
package pmon_pkg;

    // ****************************************************************
    // clock and timing
    // ****************************************************************
    localparam int unsigned CLK_MHZ        = 50;
    localparam int unsigned CONV_MIN_US    = 140;
    localparam int unsigned CONV_SEL_W     = 3;
    localparam int unsigned CONV_CNT_W     = 20;

    // ****************************************************************
    // register offsets
    // ****************************************************************
    localparam logic [7:0] ADDR_CONFIG     = 8'h00;
    localparam logic [7:0] ADDR_SHUNT      = 8'h01;
    localparam logic [7:0] ADDR_BUS        = 8'h02;
    localparam logic [7:0] ADDR_MAKER_ID   = 8'h3e;

    // ****************************************************************
    // configuration fields
    // ****************************************************************
    localparam int unsigned CFG_AVG_LSB    = 0;
    localparam int unsigned CFG_AVG_W      = 2;
    localparam int unsigned CFG_CONV_LSB   = 2;
    localparam int unsigned CFG_RANGE_BIT  = 5;
    localparam logic [15:0] CFG_WR_MASK    = 16'h003f;
    localparam logic [15:0] CFG_RESET      = 16'h0000;

    // ****************************************************************
    // arithmetic scaling
    // ****************************************************************
    localparam int unsigned CUR_SHIFT      = 11;
    localparam int unsigned PWR_DIV        = 20000;
    localparam int unsigned PWR_SHIFT      = 29;
    localparam logic [15:0] PWR_RECIP      = 16'h68db;
    localparam logic [15:0] RESULT_RESET   = 16'h0000;

    // ****************************************************************
    // types
    // ****************************************************************
    typedef struct packed {
        logic signed [15:0] shunt;
        logic        [15:0] bus;
        logic signed [15:0] current;
        logic        [15:0] power;
    } pmon_result_t;

    typedef struct packed {
        logic [7:0]  addr;
        logic        wr;
        logic [15:0] wdata;
    } pmon_reg_req_t;

    typedef enum logic [1:0] {
        PMON_CONVERT,
        PMON_MATH,
        PMON_COMMIT
    } pmon_state_t;

    // conversion time in microseconds for each select code
    function automatic int unsigned pmon_conv_us(input logic [CONV_SEL_W-1:0] sel);
        case (sel)
            3'h0:    pmon_conv_us = CONV_MIN_US;
            3'h1:    pmon_conv_us = 204;
            3'h2:    pmon_conv_us = 332;
            3'h3:    pmon_conv_us = 588;
            3'h4:    pmon_conv_us = 1100;
            3'h5:    pmon_conv_us = 2116;
            3'h6:    pmon_conv_us = 4156;
            default: pmon_conv_us = 8244;
        endcase
    endfunction

    // log2 of the averaging count: 1, 4, 16, 64 samples
    function automatic logic [2:0] pmon_avg_log2(input logic [CFG_AVG_W-1:0] sel);
        pmon_avg_log2 = {sel, 1'b0};
    endfunction

endpackage

// ==== logic/pmon_math.sv ====
/*
 * current and power arithmetic of the monitor, two cycles per result.
 * assumes start_i is a one-cycle pulse with stable operands.
 */
`timescale 1ns/1ps
`default_nettype none

module pmon_math (
    input  wire logic               clk_i,
    input  wire logic               arst_n_i,
    input  wire logic               start_i,
    input  wire logic signed [15:0] shunt_i,
    input  wire logic        [15:0] bus_i,
    input  wire logic        [15:0] cal_i,
    output logic                    done_o,
    output logic                    ovf_o,
    output logic signed      [15:0] current_o,
    output logic             [15:0] power_o
);

    // ****************************************************************
    // current stage
    // ****************************************************************
    logic signed [32:0] cur_prod;
    logic signed [32:0] cur_scaled;
    logic signed [15:0] cur_sat;
    logic               cur_ovf;
    logic               stage_q;

    // zero calibration gives a zero product and hence zero current
    assign cur_prod   = shunt_i * $signed({1'b0, cal_i}); // RL9 RL13
    assign cur_scaled = cur_prod >>> pmon_pkg::CUR_SHIFT; // RL10
    assign cur_ovf    = (cur_scaled > 33'sd32767) || (cur_scaled < -33'sd32768);
    assign cur_sat    = (cur_scaled > 33'sd32767)  ? 16'sh7fff :
                        (cur_scaled < -33'sd32768) ? 16'sh8000 : cur_scaled[15:0];

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            current_o <= 16'sh0000;
            stage_q   <= 1'b0;
        end else begin
            stage_q <= start_i;
            if (start_i) begin
                current_o <= cur_sat;
            end
        end
    end

    // ****************************************************************
    // power stage
    // ****************************************************************
    // power uses current magnitude so either current direction reads positive
    logic [15:0] cur_mag;
    logic [31:0] pwr_raw;
    logic [47:0] pwr_prod;
    logic [18:0] pwr_scaled;

    assign cur_mag    = current_o[15] ? 16'(-current_o) : current_o;
    assign pwr_raw    = cur_mag * bus_i; // RL13
    assign pwr_prod   = pwr_raw * pmon_pkg::PWR_RECIP;
    assign pwr_scaled = pwr_prod[pmon_pkg::PWR_SHIFT +: 19]; // RL12

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            power_o <= 16'h0000;
            done_o  <= 1'b0;
            ovf_o   <= 1'b0;
        end else begin
            done_o <= stage_q;
            if (start_i) begin
                ovf_o <= cur_ovf;
            end else if (stage_q) begin
                power_o <= (pwr_scaled[18:16] != 3'h0) ? 16'hffff : pwr_scaled[15:0];
                ovf_o   <= ovf_o || (pwr_scaled[18:16] != 3'h0);
            end
        end
    end

endmodule

`default_nettype wire

// ==== verification/pmon_props.sv ====
/* port checker of the monitor datapath.
   assumes a bind to pmon_datapath that hands on its parameters. */
`timescale 1ns/1ps
`default_nettype none
module pmon_props #(
    parameter int unsigned CYC_PER_US = 1,
    parameter logic [15:0] MAKER_ID   = 16'h0000
) (
    input wire logic                    clk_i,
    input wire logic                    arst_n_i,
    input wire pmon_pkg::pmon_reg_req_t reg_req_i,
    input wire logic                    reg_rd_i,
    input wire logic [15:0]             reg_rdata_o,
    input wire logic [15:0]             shunt_cal_i,
    input wire logic signed [15:0]      shunt_sample_i,
    input wire logic [15:0]             bus_sample_i,
    input wire logic                    shunt_range_select_o,
    input wire logic                    sample_strobe_o,
    input wire logic                    result_ready_o,
    input wire logic                    math_ovf_o,
    input wire pmon_pkg::pmon_result_t  result_o
);
    // one cycle of slack: a config write only ever stretches the gap
    localparam int MIN_GAP = 140 * CYC_PER_US - 2;
    logic [19:0] gap_q;
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) gap_q <= 20'h0;
        else gap_q <= sample_strobe_o ? 20'h0 : gap_q + 20'h1;
    end
    default clocking pmon_cb @(posedge clk_i); endclocking
    default disable iff (!arst_n_i);
    ident_read_a:
        assert property (reg_rd_i && reg_req_i.addr == 8'h3e |=> reg_rdata_o == MAKER_ID) else $error("bad id");
    range_write_a:
        assert property (reg_req_i.wr && reg_req_i.addr == 8'h00 |=> shunt_range_select_o == $past(reg_req_i.wdata[5]))
            else $error("bad range bit");
    shunt_read_a:
        assert property (reg_rd_i && reg_req_i.addr == 8'h01 |=> reg_rdata_o == $past(result_o.shunt))
            else $error("bad shunt read");
    rdata_hold_a:
        assert property (!reg_rd_i |=> $stable(reg_rdata_o)) else $error("read data moved");
    commit_delay_a:
        assert property (result_ready_o |-> $past(sample_strobe_o, 4)) else $error("commit not 4 after strobe");
    result_hold_a:
        assert property (!result_ready_o |-> $stable(result_o)) else $error("results moved");
    zero_cal_a:
        assert property (result_ready_o && shunt_cal_i == 16'h0000 |-> result_o.current == 16'h0000)
            else $error("current not zero");
    strobe_gap_a:
        assert property (sample_strobe_o |-> gap_q >= MIN_GAP) else $error("conversion too short");
    cover property (result_ready_o && math_ovf_o);
    cover property (reg_rd_i && reg_req_i.addr == 8'h3e);
    cover property (reg_req_i.wr && reg_req_i.wdata[5]);
endmodule
bind pmon_datapath pmon_props #(.CYC_PER_US(CYC_PER_US), .MAKER_ID(MAKER_ID)) pmon_props_inst (
    .clk_i, .arst_n_i, .reg_req_i, .reg_rd_i, .reg_rdata_o, .shunt_cal_i, .shunt_sample_i,
    .bus_sample_i, .shunt_range_select_o, .sample_strobe_o, .result_ready_o, .math_ovf_o, .result_o);
`default_nettype wire

// ==== verification/pmon_host.sv ====
/* host controller model on the register port of the monitor.
   assumes the port takes one access at each rising edge. */
`timescale 1ns/1ps
`default_nettype none
module pmon_host (
    input  wire logic                  clk_i,
    input  wire logic [15:0]           rdata_i,
    output var pmon_pkg::pmon_reg_req_t req_o,
    output logic                       rd_o,
    output logic [15:0]                cal_o
);
    initial begin
        req_o = '0;
        rd_o  = 1'b0;
        cal_o = 16'h0000;
    end
    // held through the taking edge, answer taken just after it
    task automatic xfer(input logic [7:0] a, input logic w, input logic [15:0] d, output logic [15:0] q);
        @(posedge clk_i);
        #1;
        req_o = '{addr: a, wr: w, wdata: d};
        rd_o  = !w;
        @(posedge clk_i);
        #1;
        q     = rdata_i;
        // released lines show the inverse so a stale address never passes for a live one
        req_o = '{addr: ~a, wr: 1'b0, wdata: ~d};
        rd_o  = 1'b0;
    endtask
    // word is worked out from the current step and shunt, a quarter of it in the narrow range
    task automatic set_cal(input logic [15:0] c);
        cal_o = c;
    endtask
endmodule
`default_nettype wire

// ==== verification/tb_pmon_datapath.sv ====
/* self-checking bench of the monitor datapath.
   assumes the host model drives the register port and calibration word. */
`timescale 1ns/1ps
`default_nettype none
module tb_pmon_datapath;
    localparam logic [15:0]  ID = 16'h1c3d; // arbitrary value
    logic                    clk_i, arst_n_i, rd, rng, strobe, ready, ovf;
    logic [15:0]             rdata, cal, bus_s;
    logic signed [15:0]      shunt_s;
    pmon_pkg::pmon_reg_req_t req;
    pmon_pkg::pmon_result_t  res;
    int                      miscompares, n_tests;
    pmon_datapath #(.CYC_PER_US(1), .MAKER_ID(ID)) pmon_datapath_inst (.clk_i, .arst_n_i, .reg_req_i(req),
        .reg_rd_i(rd), .reg_rdata_o(rdata), .shunt_cal_i(cal), .shunt_sample_i(shunt_s), .bus_sample_i(bus_s),
        .shunt_range_select_o(rng), .sample_strobe_o(strobe), .result_ready_o(ready), .math_ovf_o(ovf),
        .result_o(res));
    pmon_host pmon_host_inst (.clk_i, .rdata_i(rdata), .req_o(req), .rd_o(rd), .cal_o(cal));
    initial begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic rd_chk(input string what, input logic [7:0] a, input logic [15:0] exp);
        logic [15:0] q;
        pmon_host_inst.xfer(a, 1'b0, 16'h0000, q);
        chk(what, exp, q);
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        logic [15:0] q;
        pmon_host_inst.xfer(a, 1'b1, d, q);
    endtask
    // bounded so a dead strobe cannot hang the run; h counts strobes seen
    task automatic wait_for(input bit want_ready, output int n, output int h);
        n = 0;
        h = 0;
        do begin
            @(posedge clk_i);
            #1;
            n++;
            h += (strobe === 1'b1);
        end while ((want_ready ? ready : strobe) !== 1'b1 && n < 20000);
        if (n >= 20000) chk("wait", 16'h0001, 16'h0000);
    endtask
    task automatic t_regs;
        rd_chk("config reset", 8'h00, 16'h0000);
        rd_chk("identity", 8'h3e, ID);
        wr(8'h3e, 16'h0000);
        rd_chk("identity kept", 8'h3e, ID);
        rd_chk("unmapped", 8'h05, 16'h0000);
        wr(8'h00, 16'hffff);
        chk("narrow range", 16'h0001, {15'h0, rng});
        rd_chk("config mask", 8'h00, 16'h003f);
        wr(8'h00, 16'h0000);
        chk("wide range", 16'h0000, {15'h0, rng});
        $display("register test done");
    endtask
    task automatic t_meas;
        logic [15:0] s [4] = '{16'hfc18, 16'h7fff, 16'h8000, 16'h01f4};
        logic [15:0] b [4] = '{16'd20000, 16'hffff, 16'd100, 16'd300};
        logic [15:0] c [4] = '{16'd4096, 16'hffff, 16'hffff, 16'h0000};
        longint      cur, pwr;
        bit          of;
        int          n, h;
        wait_for(1'b1, n, h);
        for (int k = 0; k < 4; k++) begin
            shunt_s = s[k];
            bus_s = b[k];
            pmon_host_inst.set_cal(c[k]);
            wait_for(1'b1, n, h);
            cur = (longint'($signed(s[k])) * longint'(c[k])) >>> pmon_pkg::CUR_SHIFT;
            of = cur > 32767 || cur < -32768;
            cur = of ? (cur < 0 ? -32768 : 32767) : cur;
            pwr = ((cur < 0 ? -cur : cur) * longint'(b[k]) * longint'(pmon_pkg::PWR_RECIP)) >> pmon_pkg::PWR_SHIFT;
            of = of || pwr > 65535;
            chk("current", cur[15:0], res.current);
            chk("power", pwr > 65535 ? 16'hffff : pwr[15:0], res.power);
            chk("overflow", {15'h0, of}, {15'h0, ovf});
            rd_chk("shunt", 8'h01, s[k]);
            rd_chk("bus", 8'h02, b[k]);
        end
        $display("measurement test done");
    endtask
    task automatic t_timing;
        int us [8] = '{140, 204, 332, 588, 1100, 2116, 4156, 8244};
        int n, h;
        for (int k = 0; k < 8; k++) begin
            wr(8'h00, 16'(k << 2));
            wait_for(1'b0, n, h);
            wait_for(1'b0, n, h);
            chk("conversion cycles", 16'(us[k]), 16'(n));
        end
        for (int k = 0; k < 4; k++) begin
            wr(8'h00, 16'(k));
            wait_for(1'b1, n, h);
            wait_for(1'b1, n, h);
            chk("samples per result", 16'(1 << (2 * k)), 16'(h));
        end
        $display("timing test done");
    endtask
    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        arst_n_i = 1'b0;
        shunt_s = 16'h0000;
        bus_s = 16'h0000;
        miscompares = 0;
        n_tests = 0;
        repeat (2) @(posedge clk_i);
        #1;
        arst_n_i = 1'b1;
        t_regs();
        t_meas();
        t_timing();
        wrap_up();
    end
    // the sweeps need about 60000 cycles; the limit leaves a margin
    initial begin
        #(90000 * 20);
        miscompares++;
        wrap_up();
    end
endmodule
`default_nettype wire
